// *** src/apes_host.sv ***
// Purpose: Host controller driving auto program, chip erase and block erase on a parallel flash.
// Assumes: Pin inputs synchronous to clk_sys; device status read via poll and toggle bits.
// Notes: One operation at a time; req is taken only while req_ready is high.
`timescale 1ns/100ps
module apes_host
	import apes_pkg::*;
#(
	parameter longint ERASE_LIMIT = apes_pkg::ERASE_LIMIT_CYC,
	parameter int PROG_LIMIT = apes_pkg::PROG_MAX_CYC,
	parameter int SETTLE = apes_pkg::LOAD_SETTLE_CYC,
	parameter int SEL_SETUP = apes_pkg::SEL_SETUP_CYC
) (
	input wire logic clk_sys, // System clock 100 MHz
	input wire logic nrst, // Async reset, active low
	input wire apes_pkg::apes_req_t req, // Operation request
	output logic req_ready, // Ready to take a request
	output apes_pkg::apes_rsp_t rsp, // Completion result, one-cycle done
	output apes_pkg::apes_pins_t pins, // Flash pin drive
	input wire logic [7:0] dq_i // Flash data bus in
);
	import apes_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE, ST_VPP_UP, ST_WR_LO, ST_WR_HI, ST_NEXT, ST_LOAD_WAIT,
		ST_SETTLE, ST_SEL, ST_RD, ST_CHECK, ST_VPP_DN, ST_RESP
	} apes_st_t;

	typedef struct packed {
		apes_st_t st;
		apes_op_t op;
		logic [1:0] wr_idx;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
		logic last;
		logic [15:0] gap;
		logic have_prev;
		logic [7:0] prev;
		logic fail;
		logic timeout;
		logic done;
		apes_pins_t pins;
	} apes_state_t;

	localparam int TW = 40;
	// Last wait cycle that still takes a next load; its strobe then falls 2 cycles past the load window
	localparam int GAP_LAST = LOAD_SPACE_MAX_CYC - 2 * STROBE_CYC - 2;

	apes_state_t s_q, s_d;
	logic t_load, t_zero, w_load, w_zero, busy_tmo;
	logic [TW-1:0] t_val, w_val;

	// Short waits: strobes, spacing, settle, select setup
	apes_timer #(.W(TW)) u_wait (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.load(t_load),
		.value(t_val),
		.zero(t_zero)
	);
	// Busy watchdog for the whole auto operation
	apes_timer #(.W(TW)) u_watch (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.load(w_load),
		.value(w_val),
		.zero(w_zero)
	);

	assign busy_tmo = w_zero;

	// Command byte for each write of the sequence
	function automatic logic [7:0] cmd_byte(apes_op_t op, logic [1:0] idx, logic [7:0] data);
		logic [7:0] b;
		b = CMD_RESET;
		case (op)
			APES_OP_PROG: b = (idx == 2'd0) ? CMD_PROG : data;
			APES_OP_CHIP: b = CMD_CHIP_SETUP;
			APES_OP_BLOCK: b = (idx == 2'd0) ? CMD_BLK_SETUP : CMD_BLK_CONF;
			APES_OP_ABORT: b = CMD_RESET;
			default: b = CMD_RESET;
		endcase
		return b;
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		t_load = 1'b0;
		t_val = '0;
		w_load = 1'b0;
		w_val = '0;
		case (s_q.st)
			ST_IDLE: begin
				s_d.pins.ce_n = 1'b1;
				s_d.pins.oe_n = 1'b1;
				s_d.pins.we_n = 1'b1;
				s_d.pins.dq_oe = 1'b0;
				if (req.valid) begin
					s_d.op = req.op;
					s_d.addr = req.addr;
					s_d.data = req.data;
					s_d.last = req.last;
					s_d.wr_idx = 2'd0;
					s_d.fail = 1'b0;
					s_d.timeout = 1'b0;
					s_d.have_prev = 1'b0;
					// Supply switches only with both selects high
					s_d.pins.vpp_hi = 1'b1;
					t_load = 1'b1;
					t_val = TW'(VPP_SETUP_CYC);
					s_d.st = ST_VPP_UP;
				end
			end
			ST_VPP_UP: begin
				if (t_zero) begin
					s_d.pins.ce_n = 1'b0;
					s_d.pins.we_n = 1'b0;
					s_d.pins.addr = s_q.addr;
					s_d.pins.dq_o = cmd_byte(s_q.op, s_q.wr_idx, s_q.data);
					s_d.pins.dq_oe = 1'b1;
					t_load = 1'b1;
					t_val = TW'(STROBE_CYC);
					s_d.st = ST_WR_LO;
				end
			end
			ST_WR_LO: begin
				if (t_zero) begin
					s_d.pins.we_n = 1'b1;
					t_load = 1'b1;
					t_val = TW'(STROBE_CYC);
					s_d.st = ST_WR_HI;
				end
			end
			ST_WR_HI: begin
				if (t_zero) begin
					s_d.pins.dq_oe = 1'b0;
					s_d.wr_idx = s_q.wr_idx + 2'd1;
					s_d.st = ST_NEXT;
				end
			end
			ST_NEXT: begin
				if (s_q.wr_idx == 2'd1) begin
					// Second write of every sequence
					s_d.pins.ce_n = 1'b0;
					s_d.pins.we_n = 1'b0;
					s_d.pins.dq_o = cmd_byte(s_q.op, s_q.wr_idx, s_q.data);
					s_d.pins.dq_oe = 1'b1;
					t_load = 1'b1;
					t_val = TW'(STROBE_CYC);
					s_d.st = ST_WR_LO;
				end else if (s_q.op == APES_OP_ABORT) begin
					s_d.pins.ce_n = 1'b1;
					s_d.st = ST_VPP_DN;
				end else begin
					// Status is only meaningful after the second strobe rises
					w_load = 1'b1;
					w_val = (s_q.op == APES_OP_PROG) ? TW'(PROG_LIMIT) : TW'(ERASE_LIMIT);
					t_load = 1'b1;
					t_val = (s_q.op == APES_OP_BLOCK) ? TW'(LOAD_SPACE_MIN_CYC) : TW'(SEL_SETUP);
					s_d.gap = '0;
					s_d.st = (s_q.op == APES_OP_BLOCK) ? ST_LOAD_WAIT : ST_SEL;
				end
			end
			ST_LOAD_WAIT: begin
				s_d.gap = s_q.gap + 16'd1;
				// Further block addresses must arrive within the load window
				if (!s_q.last && req.valid && t_zero && 32'(s_q.gap) <= GAP_LAST) begin
					s_d.addr = req.addr;
					s_d.last = req.last;
					s_d.pins.addr = req.addr;
					s_d.pins.dq_o = CMD_BLK_CONF;
					s_d.pins.dq_oe = 1'b1;
					s_d.pins.we_n = 1'b0;
					s_d.wr_idx = 2'd1;
					t_load = 1'b1;
					t_val = TW'(STROBE_CYC);
					s_d.st = ST_WR_LO;
				end else if (s_q.last || 32'(s_q.gap) > GAP_LAST) begin
					// A late requester closes the list; the busy watch restarts with the erase
					w_load = 1'b1;
					w_val = TW'(ERASE_LIMIT);
					t_load = 1'b1;
					t_val = TW'(SETTLE);
					s_d.st = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (t_zero) begin
					t_load = 1'b1;
					t_val = TW'(SEL_SETUP);
					s_d.st = ST_SEL;
				end
			end
			ST_SEL: begin
				s_d.pins.ce_n = 1'b0;
				if (t_zero) begin
					s_d.pins.oe_n = 1'b0;
					t_load = 1'b1;
					t_val = TW'(STROBE_CYC);
					s_d.st = ST_RD;
				end
			end
			ST_RD: begin
				if (t_zero) begin
					// Only bits 7 and 6 are meaningful; the rest float
					s_d.prev = dq_i;
					s_d.have_prev = 1'b1;
					s_d.pins.oe_n = 1'b1;
					s_d.st = ST_CHECK;
				end
			end
			ST_CHECK: begin
				// Completion decided from status bits, never a verify read
				if (s_q.have_prev && busy_tmo) begin
					s_d.timeout = 1'b1;
					s_d.fail = 1'b1;
					s_d.pins.ce_n = 1'b1;
					s_d.st = ST_VPP_DN;
				end else begin
					t_load = 1'b1;
					t_val = TW'(STROBE_CYC);
					s_d.st = ST_SEL;
				end
			end
			ST_VPP_DN: begin
				s_d.pins.ce_n = 1'b1;
				s_d.pins.oe_n = 1'b1;
				s_d.pins.vpp_hi = 1'b0;
				s_d.st = ST_RESP;
			end
			ST_RESP: begin
				s_d.done = 1'b1;
				s_d.st = ST_IDLE;
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		// Two reads agree on bit 6: toggling stopped, judge the poll bit
		if (s_q.st == ST_RD && t_zero && s_q.have_prev && (dq_i[6] == s_q.prev[6])) begin
			if (s_q.op == APES_OP_PROG) begin
				s_d.fail = (dq_i[7] != s_q.data[7]);
			end else begin
				s_d.fail = (dq_i[7] != 1'b1);
			end
			s_d.pins.oe_n = 1'b1;
			s_d.pins.ce_n = 1'b1;
			s_d.st = ST_VPP_DN;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{st: ST_IDLE, op: APES_OP_PROG, wr_idx: 2'd0, addr: '0, data: 8'h00, last: 1'b0,
				have_prev: 1'b0, prev: 8'h00, fail: 1'b0, timeout: 1'b0, done: 1'b0, gap: 16'h0000,
				pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, vpp_hi: 1'b0, addr: '0, dq_o: 8'h00, dq_oe: 1'b0}};
		end else begin
			s_q <= s_d;
		end
	end

	assign req_ready = (s_q.st == ST_IDLE) ||
		(s_q.st == ST_LOAD_WAIT && !s_q.last && t_zero && 32'(s_q.gap) <= GAP_LAST);
	assign rsp = '{done: s_q.done, fail: s_q.fail, timeout: s_q.timeout};
	assign pins = s_q.pins;
endmodule

// *** src/apes_pkg.sv ***
// Purpose: Constants and carrier types for the flash program/erase host controller.
// Assumes: 100 MHz clk_sys; device is a byte-wide parallel flash with auto program/erase.
// Notes on behaviour
// - Host detects completion by reading poll and toggle bits, never by verify cycles.
// - Host spaces successive block address loads 0.3 to 30.02 microseconds apart.
// - After the last block load the host waits at least 100 microseconds.
// - Chip select and output enable stay high while the supply switches levels.
// - Host never switches the programming supply while chip select is low.
// - Host holds chip select at least 6 microseconds before a status read.
// - Block erase is set-up code 20H then confirm D0H with a block address.
// - Two writes of FFH abort a set-up or failed operation without changing memory.
package apes_pkg;

	localparam int ADDR_W = 18;
	localparam int CLK_MHZ = 100;

	// Command codes
	localparam logic [7:0] CMD_PROG = 8'h40;
	localparam logic [7:0] CMD_CHIP_SETUP = 8'h30;
	localparam logic [7:0] CMD_BLK_SETUP = 8'h20;
	localparam logic [7:0] CMD_BLK_CONF = 8'hD0;
	localparam logic [7:0] CMD_RESET = 8'hFF;

	// Times in their own units
	localparam int PROG_MAX_US = 300;
	localparam int ERASE_TYP_S = 5;
	localparam int LOAD_SPACE_MIN_NS = 300;
	localparam int LOAD_SPACE_MAX_US = 30;
	localparam int LOAD_SETTLE_US = 100;
	localparam int SEL_SETUP_US = 6;
	localparam int VPP_SETUP_NS = 100;
	localparam int STROBE_NS = 50;

	// Cycle counts: least times round up, longest round down
	localparam int LOAD_SPACE_MIN_CYC = (LOAD_SPACE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int LOAD_SPACE_MAX_CYC = LOAD_SPACE_MAX_US * CLK_MHZ;
	localparam int LOAD_SETTLE_CYC = LOAD_SETTLE_US * CLK_MHZ;
	localparam int SEL_SETUP_CYC = SEL_SETUP_US * CLK_MHZ;
	localparam int VPP_SETUP_CYC = (VPP_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
	localparam longint ERASE_TYP_CYC = 64'(ERASE_TYP_S) * 64'd1000000 * 64'(CLK_MHZ);
	// Give up after four typical erase times
	localparam longint ERASE_LIMIT_CYC = ERASE_TYP_CYC * 4;

	typedef enum logic [1:0] {
		APES_OP_PROG,
		APES_OP_CHIP,
		APES_OP_BLOCK,
		APES_OP_ABORT
	} apes_op_t;

	typedef struct packed {
		logic valid;
		apes_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
		logic last;
	} apes_req_t;

	typedef struct packed {
		logic done;
		logic fail;
		logic timeout;
	} apes_rsp_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic vpp_hi;
		logic [ADDR_W-1:0] addr;
		logic [7:0] dq_o;
		logic dq_oe;
	} apes_pins_t;

endpackage

// *** src/apes_timer.sv ***
// Purpose: Loadable down-counter flagging expiry of a wait.
// Assumes: Load may come while counting; load then takes priority over count.
// Notes: Width is a parameter so erase limits fit.
`timescale 1ns/100ps
module apes_timer #(
	parameter int W = 32
) (
	input wire logic clk_sys, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic load, // Load new count
	input wire logic [W-1:0] value, // Count to load
	output logic zero // Count has reached zero
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= value;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	assign zero = (cnt_q == '0);
endmodule

// *** testbench/apes_flash_model.sv ***
// Purpose: Behavioural flash device for the host bench
// Assumes: Pins registered on clk_sys
// Notes: Undriven bits show a moving pattern, never a stale value
`timescale 1ns/100ps
module apes_flash_model
	import apes_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic nrst, // Reset
	input wire apes_pkg::apes_pins_t pins, // Host drive
	input wire logic [31:0] busy_cyc, // Operation length
	input wire logic bad, // Wrong final bit 7
	output logic [7:0] dq_i // Data to host
);
	logic we_q, oe_q, tog, armed, prog, wr;
	logic [7:0] cmd, val, pat;
	logic [31:0] left;
	assign wr = pins.we_n && !we_q && !pins.ce_n;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			{tog, armed, prog, cmd, val, pat, left} <= '0;
			we_q <= 1'b1;
			oe_q <= 1'b1;
		end else begin
			we_q <= pins.we_n;
			oe_q <= pins.oe_n;
			pat <= pat + 8'h3B;
			if (left != 0) left <= left - 1;
			if (left != 0 && !pins.oe_n && oe_q) tog <= ~tog;
			if (wr && armed && cmd == CMD_PROG) begin
				val <= pins.dq_o;
				prog <= 1'b1;
				left <= busy_cyc;
				armed <= 1'b0;
			end else if (wr && armed && cmd == CMD_RESET && pins.dq_o == CMD_RESET) begin
				left <= '0;
				armed <= 1'b0;
			end else if (wr && armed && ((cmd == CMD_CHIP_SETUP && pins.dq_o == CMD_CHIP_SETUP)
					|| (cmd == CMD_BLK_SETUP && pins.dq_o == CMD_BLK_CONF))) begin
				prog <= 1'b0;
				left <= busy_cyc;
				armed <= cmd == CMD_BLK_SETUP;
			end else if (wr) begin
				cmd <= pins.dq_o;
				armed <= 1'b1;
			end
		end
	end
	always_comb begin
		if (pins.ce_n || pins.oe_n) dq_i = pat;
		else if (left != 0) dq_i = {prog & ~val[7], tog, pat[5:0]};
		else if (prog) dq_i = {val[7] ^ bad, val[6:0]};
		else dq_i = {~bad, 7'h7F};
	end
endmodule

// *** testbench/apes_host_sva.sv ***
// Purpose: Pin-level checks of the flash host controller
// Assumes: Bound to apes_host
// Notes: Helper counters saturate so long waits never wrap
`timescale 1ns/100ps
module apes_host_sva
	import apes_pkg::*;
#(
	parameter longint ERASE_LIMIT = 2000,
	parameter int PROG_LIMIT = 500,
	parameter int SETTLE = 50,
	parameter int SEL_SETUP = 20
) (
	input wire logic clk_sys, // Clock
	input wire logic nrst, // Reset
	input wire apes_pkg::apes_req_t req, // Request
	input wire logic req_ready, // Ready
	input wire apes_pkg::apes_rsp_t rsp, // Result
	input wire apes_pkg::apes_pins_t pins, // Pin drive
	input wire logic [7:0] dq_i // Data in
);
	logic [15:0] ce_q, ld_q, we_q;
	logic blk_q, idle;
	assign idle = req.valid && req_ready && !pins.vpp_hi;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ce_q <= '0;
			ld_q <= 16'hFFFF;
			we_q <= '0;
			blk_q <= 1'b0;
		end else begin
			ce_q <= pins.ce_n ? '0 : ce_q + 16'(ce_q != 16'hFFFF);
			ld_q <= ($fell(pins.we_n) && pins.dq_o == CMD_BLK_CONF) ? '0 : ld_q + 16'(ld_q != 16'hFFFF);
			we_q <= $rose(pins.we_n) ? '0 : we_q + 16'(we_q != 16'hFFFF);
			blk_q <= rsp.done ? 1'b0 : blk_q | (!pins.we_n && pins.dq_o == CMD_BLK_CONF);
		end
	end
	property p_vce; $changed(pins.vpp_hi) |-> pins.ce_n && $past(pins.ce_n); endproperty
	a_vce: assert property (p_vce) else $error("supply moved, select low");
	property p_voe; $changed(pins.vpp_hi) |-> pins.oe_n && $past(pins.oe_n); endproperty
	a_voe: assert property (p_voe) else $error("supply moved, read low");
	property p_sel; $fell(pins.oe_n) |-> ce_q >= SEL_SETUP; endproperty
	a_sel: assert property (p_sel) else $error("select setup short");
	property p_spc; $fell(pins.we_n) && pins.dq_o == CMD_BLK_CONF |-> ld_q + 1 >= LOAD_SPACE_MIN_CYC; endproperty
	a_spc: assert property (p_spc) else $error("block loads too close");
	property p_gap; $fell(pins.we_n) && pins.dq_o == CMD_BLK_CONF && blk_q |-> ld_q + 1 <= LOAD_SPACE_MAX_CYC;
	endproperty
	a_gap: assert property (p_gap) else $error("block loads too far apart");
	property p_set; $fell(pins.oe_n) && blk_q |-> we_q >= SETTLE; endproperty
	a_set: assert property (p_set) else $error("status read before settle");
	property p_rd; !pins.oe_n |-> !pins.dq_oe && pins.we_n; endproperty
	a_rd: assert property (p_rd) else $error("write during status read");
	property p_end; $rose(rsp.done) |-> pins.ce_n && !pins.vpp_hi; endproperty
	a_end: assert property (p_end) else $error("done with select or supply on");
	property p_blk; idle && req.op == APES_OP_BLOCK |-> ##[1:40] ($fell(pins.we_n) && pins.dq_o == CMD_BLK_SETUP);
	endproperty
	a_blk: assert property (p_blk) else $error("block set-up code missing");
	property p_abt; idle && req.op == APES_OP_ABORT |-> ##[1:40] ($fell(pins.we_n) && pins.dq_o == CMD_RESET);
	endproperty
	a_abt: assert property (p_abt) else $error("abort code missing");
	c_ok: cover property (rsp.done && !rsp.fail);
	c_to: cover property (rsp.done && rsp.timeout);
	c_ld: cover property ($fell(pins.we_n) && pins.dq_o == CMD_BLK_CONF);
endmodule
bind apes_host apes_host_sva #(.ERASE_LIMIT(ERASE_LIMIT), .PROG_LIMIT(PROG_LIMIT), .SETTLE(SETTLE),
	.SEL_SETUP(SEL_SETUP)) u_sva (.clk_sys(clk_sys), .nrst(nrst), .req(req), .req_ready(req_ready),
	.rsp(rsp), .pins(pins), .dq_i(dq_i));

// *** testbench/apes_host_tb.sv ***
// Purpose: Self-checking bench for the flash host controller
// Assumes: Shortened counts through parameters
// Notes: Flash model answers promptly, slowly or wrongly on command
`timescale 1ns/100ps
module apes_host_tb;
	import apes_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic bad = 1'b0;
	logic [31:0] busy_cyc = 32'h1E;
	apes_req_t req = '0;
	logic req_ready;
	apes_rsp_t rsp;
	apes_pins_t pins;
	logic [7:0] dq_i;
	int fail_count = 0;
	int num_checks = 0;
	always #5 clk_sys = ~clk_sys;
	apes_host #(.ERASE_LIMIT(2000), .PROG_LIMIT(500), .SETTLE(50), .SEL_SETUP(20)) DUT (.clk_sys(clk_sys),
		.nrst(nrst), .req(req), .req_ready(req_ready), .rsp(rsp), .pins(pins), .dq_i(dq_i));
	apes_flash_model FLASH (.clk_sys(clk_sys), .nrst(nrst), .pins(pins), .busy_cyc(busy_cyc), .bad(bad),
		.dq_i(dq_i));
	task automatic close_out();
		if (fail_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic issue(input apes_op_t op, input logic [17:0] a, input logic [7:0] d, input logic last);
		int n = 0;
		while (req_ready !== 1'b1 && n < 9000) begin
			@(posedge clk_sys);
			#1 n++;
		end
		req = '{1'b1, op, a, d, last};
		@(posedge clk_sys);
		#1 req.valid = 1'b0;
	endtask
	task automatic finish_op(input logic [1:0] exp, input string msg);
		int n = 0;
		while (rsp.done !== 1'b1 && n < 9000) begin
			@(posedge clk_sys);
			#1 n++;
		end
		check({5'h0, rsp.done, rsp.fail, rsp.timeout}, {5'h1, exp}, msg);
	endtask
	task automatic t_prog(input logic [7:0] d, input int busy, input logic bd, input logic [1:0] exp);
		busy_cyc = 32'(busy);
		bad = bd;
		issue(APES_OP_PROG, 18'h1234, d, 1'b0);
		finish_op(exp, "program result");
		check(FLASH.val, d, "programmed byte");
	endtask
	task automatic t_erase(input logic bd, input logic [1:0] exp);
		busy_cyc = 32'd800;
		bad = bd;
		issue(APES_OP_CHIP, 18'h0, 8'h0, 1'b0);
		finish_op(exp, "chip erase result");
	endtask
	task automatic t_block();
		busy_cyc = 32'd800;
		bad = 1'b0;
		for (int i = 0; i < 3; i++) issue(APES_OP_BLOCK, 18'(i) << 12, 8'h0, i == 2);
		finish_op(2'b00, "block erase result");
	endtask
	task automatic t_block_late();
		busy_cyc = 32'd800;
		bad = 1'b0;
		issue(APES_OP_BLOCK, 18'h3F000, 8'h0, 1'b0);
		repeat (LOAD_SPACE_MAX_CYC + 40) @(posedge clk_sys);
		#1 check({7'h0, req_ready}, 8'h00, "late block load still accepted");
		finish_op(2'b00, "lone block erase result");
	endtask
	task automatic t_abort();
		issue(APES_OP_ABORT, 18'h0, 8'h0, 1'b0);
		finish_op(2'b00, "abort result");
		check({6'h0, FLASH.armed, FLASH.left != 0}, 8'h00, "abort left device busy or armed");
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		#1 nrst = 1'b1;
		t_prog(8'h5A, 30, 1'b0, 2'b00);
		t_prog(8'hA5, 400, 1'b0, 2'b00);
		t_prog(8'hA5, 30, 1'b1, 2'b10);
		t_erase(1'b0, 2'b00);
		t_erase(1'b1, 2'b10);
		t_block();
		t_block_late();
		t_abort();
		t_prog(8'h5A, 3000, 1'b0, 2'b11);
		t_abort();
		t_prog(8'h3C, 30, 1'b0, 2'b00);
		close_out();
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		close_out();
	end
endmodule
